// ---- common/apor_defines.vh ----
`ifndef APOR_DEFINES_VH
`define APOR_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define APOR_LEFT_STATE_UP_ADDR 8'h25
`define APOR_RIGHT_OVR_LO_ADDR 8'h26
`define APOR_RIGHT_OVR_UP_ADDR 8'h27
`define APOR_RIGHT_STATE_LO_ADDR 8'h28
`define APOR_RIGHT_STATE_UP_ADDR 8'h29

// ----------------------------------------
// Reset values
// ----------------------------------------
`define APOR_LEFT_STATE_UP_RST 8'h00
`define APOR_RIGHT_OVR_LO_RST 8'h00
`define APOR_RIGHT_OVR_UP_RST 8'h00
`define APOR_RIGHT_STATE_LO_RST 8'h00
`define APOR_RIGHT_STATE_UP_RST 8'h00

// ----------------------------------------
// Field positions, upper registers
// ----------------------------------------
`define APOR_GAIN_BIT 7
`define APOR_MUTE_BIT 6
`define APOR_DUMMY_MUTE_BIT 5
`define APOR_CHARGE_PUMP_BIT 4
`define APOR_OFFSET_CAL_BIT 3
`define APOR_SHORT_PROT_BIT 2
`define APOR_IMP_SENSE_BIT 1
`define APOR_IMP_WHOLE_BIT 0

// ----------------------------------------
// Field positions, lower registers
// ----------------------------------------
`define APOR_CONV_BIT 4
`define APOR_DRIVER_BIT 3
`define APOR_BIAS_BIT 2
`define APOR_CM_FEEDBACK_BIT 1
`define APOR_OUT_STAGE_BIT 0
`define APOR_LO_FIELD_MSB 4
`define APOR_RSVD_UP_BIT 4

`endif

// ---- verilog/apor_regs.v ----
// Function
// - Bit 7 of 0x25 forces left gain control power; 1 up, reset 0.
// - Bits 6,5 of 0x25 force left mute and dummy mute power; reset 0.
// - Bit 4 of 0x25 forces negative charge pump power; reset 0.
// - Bits 3,2,1 of 0x25 force left offset cal, short prot, imp sense.
// - Bit 0 of 0x25 forces left whole-power-down impedance sense; reset 0.
// - 0x26 bits 4..0 are right lower-group override enables; 7..5 reserved.
// - 0x27 bits 7,6,5 override right gain, mute, dummy mute; bit 4 reserved.
// - 0x27 bits 3,2,1 override right offset cal, short prot, imp sense.
// - 0x27 bit 0 overrides right whole-power-down impedance sense; reset 0.
// - 0x28 bits 4..0 hold right lower-group forced states; reset 0.
// - 0x29 holds right upper-group forced states; bit 4 reserved; reset 0.
`timescale 1ns/10ps
`include "apor_defines.vh"

module apor_regs #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    // Clock and reset
    input wire CLK,
    input wire RESET_N,
    // Register port from the serial control decoder
    input wire [ADDR_W-1:0] REG_ADDR,
    input wire [DATA_W-1:0] REG_WDATA,
    input wire REG_WR,
    output reg [DATA_W-1:0] REG_RDATA,
    // Normal power sequencing, right channel
    input wire [4:0] RIGHT_SEQ_PWR_LO,
    input wire [7:0] RIGHT_SEQ_PWR_UP,
    // Left forced states, charge pump at bit 4
    output wire [7:0] LEFT_FORCED_STATE,
    // Resolved right power controls, 1 means power up
    output wire [4:0] RIGHT_PWR_LO,
    output wire [7:0] RIGHT_PWR_UP
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg [7:0] left_state_up_q;
    reg [7:0] right_ovr_lo_q;
    reg [7:0] right_ovr_up_q;
    reg [7:0] right_state_lo_q;
    reg [7:0] right_state_up_q;

    wire wr_left_state_up;
    wire wr_right_ovr_lo;
    wire wr_right_ovr_up;
    wire wr_right_state_lo;
    wire wr_right_state_up;

    function hit;
        input [ADDR_W-1:0] addr;
        input [7:0] offs;
        begin
            hit = (addr == offs);
        end
    endfunction

    assign wr_left_state_up = REG_WR && hit(REG_ADDR, `APOR_LEFT_STATE_UP_ADDR);
    assign wr_right_ovr_lo = REG_WR && hit(REG_ADDR, `APOR_RIGHT_OVR_LO_ADDR);
    assign wr_right_ovr_up = REG_WR && hit(REG_ADDR, `APOR_RIGHT_OVR_UP_ADDR);
    assign wr_right_state_lo = REG_WR && hit(REG_ADDR, `APOR_RIGHT_STATE_LO_ADDR);
    assign wr_right_state_up = REG_WR && hit(REG_ADDR, `APOR_RIGHT_STATE_UP_ADDR);

    // Reserved bits are R/W storage and read back what was written
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            left_state_up_q <= `APOR_LEFT_STATE_UP_RST;
            right_ovr_lo_q <= `APOR_RIGHT_OVR_LO_RST;
            right_ovr_up_q <= `APOR_RIGHT_OVR_UP_RST;
            right_state_lo_q <= `APOR_RIGHT_STATE_LO_RST;
            right_state_up_q <= `APOR_RIGHT_STATE_UP_RST;
        end else begin
            if (wr_left_state_up) begin
                left_state_up_q <= REG_WDATA[7:0];
            end
            if (wr_right_ovr_lo) begin
                right_ovr_lo_q <= REG_WDATA[7:0];
            end
            if (wr_right_ovr_up) begin
                right_ovr_up_q <= REG_WDATA[7:0];
            end
            if (wr_right_state_lo) begin
                right_state_lo_q <= REG_WDATA[7:0];
            end
            if (wr_right_state_up) begin
                right_state_up_q <= REG_WDATA[7:0];
            end
        end
    end

    // ----------------------------------------
    // Read back, one cycle after the address
    // ----------------------------------------
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= {DATA_W{1'b0}};
        end else begin
            case (REG_ADDR)
                `APOR_LEFT_STATE_UP_ADDR: begin
                    REG_RDATA <= left_state_up_q;
                end
                `APOR_RIGHT_OVR_LO_ADDR: begin
                    REG_RDATA <= right_ovr_lo_q;
                end
                `APOR_RIGHT_OVR_UP_ADDR: begin
                    REG_RDATA <= right_ovr_up_q;
                end
                `APOR_RIGHT_STATE_LO_ADDR: begin
                    REG_RDATA <= right_state_lo_q;
                end
                `APOR_RIGHT_STATE_UP_ADDR: begin
                    REG_RDATA <= right_state_up_q;
                end
                default: begin
                    // Unmapped offsets belong to other banks; answer zero
                    REG_RDATA <= {DATA_W{1'b0}};
                end
            endcase
        end
    end

    // ----------------------------------------
    // Named fields, left forced states
    // ----------------------------------------
    wire left_gain_pwr_state;
    wire left_mute_pwr_state;
    wire left_dummy_mute_pwr_state;
    wire charge_pump_pwr_state;
    wire left_offset_cal_pwr_state;
    wire left_short_prot_pwr_state;
    wire left_imp_sense_pwr_state;
    wire left_imp_whole_pwr_state;

    assign left_gain_pwr_state = left_state_up_q[`APOR_GAIN_BIT];
    assign left_mute_pwr_state = left_state_up_q[`APOR_MUTE_BIT];
    assign left_dummy_mute_pwr_state = left_state_up_q[`APOR_DUMMY_MUTE_BIT];
    assign charge_pump_pwr_state = left_state_up_q[`APOR_CHARGE_PUMP_BIT];
    assign left_offset_cal_pwr_state = left_state_up_q[`APOR_OFFSET_CAL_BIT];
    assign left_short_prot_pwr_state = left_state_up_q[`APOR_SHORT_PROT_BIT];
    assign left_imp_sense_pwr_state = left_state_up_q[`APOR_IMP_SENSE_BIT];
    assign left_imp_whole_pwr_state = left_state_up_q[`APOR_IMP_WHOLE_BIT];

    // ----------------------------------------
    // Named fields, right override enables
    // ----------------------------------------
    wire right_conv_force_en;
    wire right_driver_force_en;
    wire right_bias_force_en;
    wire right_cm_feedback_force_en;
    wire right_out_stage_force_en;
    wire right_gain_force_en;
    wire right_mute_force_en;
    wire right_dummy_mute_force_en;
    wire right_offset_cal_force_en;
    wire right_short_prot_force_en;
    wire right_imp_sense_force_en;
    wire right_imp_whole_force_en;

    assign right_conv_force_en = right_ovr_lo_q[`APOR_CONV_BIT];
    assign right_driver_force_en = right_ovr_lo_q[`APOR_DRIVER_BIT];
    assign right_bias_force_en = right_ovr_lo_q[`APOR_BIAS_BIT];
    assign right_cm_feedback_force_en = right_ovr_lo_q[`APOR_CM_FEEDBACK_BIT];
    assign right_out_stage_force_en = right_ovr_lo_q[`APOR_OUT_STAGE_BIT];
    assign right_gain_force_en = right_ovr_up_q[`APOR_GAIN_BIT];
    assign right_mute_force_en = right_ovr_up_q[`APOR_MUTE_BIT];
    assign right_dummy_mute_force_en = right_ovr_up_q[`APOR_DUMMY_MUTE_BIT];
    assign right_offset_cal_force_en = right_ovr_up_q[`APOR_OFFSET_CAL_BIT];
    assign right_short_prot_force_en = right_ovr_up_q[`APOR_SHORT_PROT_BIT];
    assign right_imp_sense_force_en = right_ovr_up_q[`APOR_IMP_SENSE_BIT];
    assign right_imp_whole_force_en = right_ovr_up_q[`APOR_IMP_WHOLE_BIT];

    // ----------------------------------------
    // Named fields, right forced states
    // ----------------------------------------
    wire right_conv_pwr_state;
    wire right_driver_pwr_state;
    wire right_bias_pwr_state;
    wire right_cm_feedback_pwr_state;
    wire right_out_stage_pwr_state;
    wire right_gain_pwr_state;
    wire right_mute_pwr_state;
    wire right_dummy_mute_pwr_state;
    wire right_offset_cal_pwr_state;
    wire right_short_prot_pwr_state;
    wire right_imp_sense_pwr_state;
    wire right_imp_whole_pwr_state;

    assign right_conv_pwr_state = right_state_lo_q[`APOR_CONV_BIT];
    assign right_driver_pwr_state = right_state_lo_q[`APOR_DRIVER_BIT];
    assign right_bias_pwr_state = right_state_lo_q[`APOR_BIAS_BIT];
    assign right_cm_feedback_pwr_state = right_state_lo_q[`APOR_CM_FEEDBACK_BIT];
    assign right_out_stage_pwr_state = right_state_lo_q[`APOR_OUT_STAGE_BIT];
    assign right_gain_pwr_state = right_state_up_q[`APOR_GAIN_BIT];
    assign right_mute_pwr_state = right_state_up_q[`APOR_MUTE_BIT];
    assign right_dummy_mute_pwr_state = right_state_up_q[`APOR_DUMMY_MUTE_BIT];
    assign right_offset_cal_pwr_state = right_state_up_q[`APOR_OFFSET_CAL_BIT];
    assign right_short_prot_pwr_state = right_state_up_q[`APOR_SHORT_PROT_BIT];
    assign right_imp_sense_pwr_state = right_state_up_q[`APOR_IMP_SENSE_BIT];
    assign right_imp_whole_pwr_state = right_state_up_q[`APOR_IMP_WHOLE_BIT];

    // ----------------------------------------
    // Power control resolution
    // ----------------------------------------
    wire [4:0] ovr_lo_vec;
    wire [4:0] state_lo_vec;
    wire [7:0] ovr_up_vec;
    wire [7:0] state_up_vec;

    // Override set takes the state bit, clear takes the sequencer
    function pick;
        input ovr;
        input state;
        input seq;
        begin
            pick = ovr ? state : seq;
        end
    endfunction

    // Left overrides live outside this bank, so states go out raw
    assign LEFT_FORCED_STATE = {left_gain_pwr_state, left_mute_pwr_state,
        left_dummy_mute_pwr_state, charge_pump_pwr_state, left_offset_cal_pwr_state,
        left_short_prot_pwr_state, left_imp_sense_pwr_state,
        left_imp_whole_pwr_state};

    assign ovr_lo_vec = {right_conv_force_en, right_driver_force_en, right_bias_force_en,
        right_cm_feedback_force_en, right_out_stage_force_en};
    assign state_lo_vec = {right_conv_pwr_state, right_driver_pwr_state, right_bias_pwr_state,
        right_cm_feedback_pwr_state, right_out_stage_pwr_state};
    // Reserved bit 4 has no sub-block: a hard zero override lets sequencing pass
    assign ovr_up_vec = {right_gain_force_en, right_mute_force_en, right_dummy_mute_force_en,
        1'b0, right_offset_cal_force_en, right_short_prot_force_en,
        right_imp_sense_force_en, right_imp_whole_force_en};
    assign state_up_vec = {right_gain_pwr_state, right_mute_pwr_state,
        right_dummy_mute_pwr_state, 1'b0, right_offset_cal_pwr_state,
        right_short_prot_pwr_state, right_imp_sense_pwr_state,
        right_imp_whole_pwr_state};

    genvar i;
    generate
        for (i = 0; i <= `APOR_LO_FIELD_MSB; i = i + 1) begin : g_lo
            assign RIGHT_PWR_LO[i] = pick(ovr_lo_vec[i], state_lo_vec[i],
                RIGHT_SEQ_PWR_LO[i]);
        end
        for (i = 0; i < 8; i = i + 1) begin : g_up
            assign RIGHT_PWR_UP[i] = pick(ovr_up_vec[i], state_up_vec[i],
                RIGHT_SEQ_PWR_UP[i]);
        end
    endgenerate

endmodule // apor_regs

// ---- verif/apor_regs_sva.sv ----
`timescale 1ns/10ps
module apor_regs_sva (
    // Clock and reset
    input logic CLK,
    input logic RESET_N,
    // Register port
    input logic REG_WR,
    input logic [7:0] REG_ADDR,
    input logic [7:0] REG_WDATA,
    input logic [7:0] REG_RDATA,
    // Power controls
    input logic [7:0] RIGHT_SEQ_PWR_UP,
    input logic [7:0] LEFT_FORCED_STATE,
    input logic [7:0] RIGHT_PWR_UP,
    input logic [4:0] RIGHT_SEQ_PWR_LO,
    input logic [4:0] RIGHT_PWR_LO
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic [7:0] sh_q [5];
    logic [7:0] rd_q;
    wire map = REG_ADDR >= 8'h25 && REG_ADDR <= 8'h29;
    wire [2:0] idx = REG_ADDR[2:0] - 3'h5;
    wire [7:0] rd_d = map ? sh_q[idx] : 8'h00;
    // Right bit 4 is reserved, never an override
    wire [7:0] ovr_up = sh_q[2] & 8'hef;
    // --------------------------------
    // Shadow of the bank
    // --------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < 5; i++)
                sh_q[i] <= 8'h00;
            rd_q <= 8'h00;
        end else begin
            if (REG_WR && map)
                sh_q[idx] <= REG_WDATA;
            rd_q <= rd_d;
        end
    end
    a_left_copy: assert property (REG_WR && REG_ADDR == 8'h25
        |=> LEFT_FORCED_STATE == $past(REG_WDATA)) else $error("left state not written");
    a_left_hold: assert property (!(REG_WR && REG_ADDR == 8'h25)
        |=> $stable(LEFT_FORCED_STATE)) else $error("left state changed unasked");
    a_read_data: assert property (REG_RDATA == rd_q)
        else $error("read data wrong");
    a_unmapped_zero: assert property (!map |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_right_lo_mux: assert property (
        RIGHT_PWR_LO == (sh_q[1][4:0] & sh_q[3][4:0] | ~sh_q[1][4:0] & RIGHT_SEQ_PWR_LO))
        else $error("right lower power wrong");
    a_right_up_mux: assert property (
        RIGHT_PWR_UP == (ovr_up & sh_q[4] | ~ovr_up & RIGHT_SEQ_PWR_UP))
        else $error("right upper power wrong");
    a_reserved_pass: assert property (RIGHT_PWR_UP[4] == RIGHT_SEQ_PWR_UP[4])
        else $error("reserved bit forced");
    a_write_readback: assert property (
        REG_WR && map ##1 REG_ADDR == $past(REG_ADDR) |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("readback after write wrong");
    c_force_gain: cover property (REG_WR && REG_ADDR == 8'h27 && REG_WDATA[7]);
    c_unmapped_write: cover property (REG_WR && !map);
    c_override_diff: cover property (sh_q[1][4:0] != 5'h00 && RIGHT_PWR_LO != RIGHT_SEQ_PWR_LO);
endmodule // apor_regs_sva
bind apor_regs apor_regs_sva chk_u (.CLK, .RESET_N, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .RIGHT_SEQ_PWR_UP, .LEFT_FORCED_STATE, .RIGHT_PWR_UP, .RIGHT_SEQ_PWR_LO, .RIGHT_PWR_LO);

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic CLK = 1'b0, RESET_N = 1'b0, REG_WR = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, RIGHT_SEQ_PWR_UP = 8'h5a;
    logic [7:0] REG_RDATA, LEFT_FORCED_STATE, RIGHT_PWR_UP;
    logic [4:0] RIGHT_SEQ_PWR_LO = 5'h15, RIGHT_PWR_LO;
    logic [7:0] d [5] = '{8'ha5, 8'hea, 8'hff, 8'h68, 8'h00};
    int num_errors = 0, compares = 0;
    apor_regs dut_u (.CLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RDATA, .RIGHT_SEQ_PWR_LO,
        .RIGHT_SEQ_PWR_UP, .LEFT_FORCED_STATE, .RIGHT_PWR_LO, .RIGHT_PWR_UP);
    always #5 CLK = ~CLK;
    // --------------------------------
    // Access tasks and checks
    // --------------------------------
    function logic [7:0] pw(input logic [7:0] o, s, q);
        return o & s | ~o & q;
    endfunction
    task chk(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, v);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task rd(input logic [7:0] a, exp);
        @(posedge CLK);
        REG_ADDR <= a;
        @(posedge CLK);
        @(negedge CLK);
        chk(REG_RDATA, exp);
    endtask
    task end_of_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #20000;
        $display("mismatch at %0t: timeout", $time);
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(8'(8'h25 + i), 8'h00);
        chk({3'b0, RIGHT_PWR_LO}, 8'h15);
        chk(RIGHT_PWR_UP, 8'h5a);
        chk(LEFT_FORCED_STATE, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 5; i++)
            wr(8'(8'h25 + i), d[i]);
        wr(8'h2a, 8'hff);
        for (int i = 0; i < 5; i++)
            rd(8'(8'h25 + i), d[i]);
        rd(8'h2a, 8'h00);
        chk(LEFT_FORCED_STATE, 8'ha5);
        chk({3'b0, RIGHT_PWR_LO}, pw(8'h0a, 8'h08, 8'h15));
        chk(RIGHT_PWR_UP, 8'h10);
        $display("test readback done");
        wr(8'h29, 8'hff);
        RIGHT_SEQ_PWR_LO <= 5'h0a;
        @(negedge CLK);
        chk({3'b0, RIGHT_PWR_LO}, pw(8'h0a, 8'h08, 8'h0a));
        chk(RIGHT_PWR_UP, 8'hff);
        wr(8'h27, 8'h00);
        @(negedge CLK);
        chk(RIGHT_PWR_UP, 8'h5a);
        $display("test override done");
        @(posedge CLK);
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(8'(8'h25 + i), 8'h00);
        chk(LEFT_FORCED_STATE, 8'h00);
        chk({3'b0, RIGHT_PWR_LO}, 8'h0a);
        chk(RIGHT_PWR_UP, 8'h5a);
        $display("test second reset done");
        end_of_test;
    end
endmodule // tb_top
